// >>> paged_instruction_decoder.sv
// Fetch and decode front end with page select and legacy register behaviours
`timescale 1ns/1ps
`include "pdec_defs.svh"

// Overview of operation
// - Instruction is optional page byte, one opcode byte, then optional operands.
// - Four pages of 256 opcodes; page zero opcodes need no page byte.
// - Bytes 17, 27, 37 on page zero select pages one, two, three.
// - Operands are four, eight or sixteen bits, as bytes or words.
// - Instruction memory is read as 16-bit words from even addresses only.
// - Every encoding has an even byte count, next one word aligned.
// - A nibble operand is zero-extended to a byte or packed in pairs.
// - Instructions are at most six bytes including page byte and operands.
// - Operand size, order and meaning come from decoding the opcode.
// - Page zero opcode and 8-bit operand arrive in one word fetch.
// - Stack to index transfer adds two to stack pointer with extension.
// - Index to stack transfer subtracts two from index with extension.
// - Index to index transfer also copies the extension field.
// - Interrupt return restores only program counter and condition codes.
// - Subroutine return pops a two-word stack frame.
// - Wait stalls with no timeout until interrupt or reset.
// - Jump and call use 20-bit indexed and 20-bit extended addressing.
module paged_instruction_decoder
   import pdec_pkg::*;
(
   // Clock and reset
   input  wire logic        sys_clk,
   input  wire logic        rst_n,
   // Program memory
   output logic             mem_req,
   output logic [19:0]      mem_addr,
   input  wire logic [15:0] mem_rdata,
   input  wire logic        mem_ack,
   // Core side
   input  wire logic        irq_req,
   input  wire logic        reg_wr_en,
   input  wire logic [1:0]  reg_wr_sel,
   input  wire logic [19:0] reg_wr_data,
   output logic             instr_valid,
   output instr_t           instr,
   output logic             illegal_op,
   output logic             call_op,
   output logic             waiting,
   // Architectural state
   output logic [19:0]      prog_cnt,
   output logic [19:0]      stack_ptr,
   output logic [19:0]      index_x,
   output logic [19:0]      index_y,
   output logic [15:0]      condition_code_reg
);

   state_t      st_ff;
   instr_t      cur_ff;
   logic [1:0]  words_left_ff;
   logic [1:0]  pop_cnt_ff;
   logic        pop_rti_ff;

   // Operand layout is a property of page and opcode, never of the stream
   function automatic fmt_t decode_fmt(input page_t pg, input logic [7:0] op);
      fmt_t f;
      f = '{legal: 1'b1, kind: ARG_NONE, words: 2'h0};
      if (pg == 2'h0) begin
         case (op[7:6])
            2'h0:    f = '{legal: 1'b1, kind: ARG_IMM8, words: 2'h0};
            2'h1:    f = '{legal: 1'b1, kind: ARG_PAIR, words: 2'h0};
            2'h2:    f = '{legal: 1'b1, kind: ARG_NIBZ, words: 2'h1};
            default: f = '{legal: 1'b1, kind: ARG_IMM8, words: 2'h2};
         endcase
      end else begin
         case (op[7:6])
            2'h0:    f.words = 2'h0;
            2'h1:    f.words = 2'h1;
            2'h2:    f.words = 2'h2;
            default: f.legal = (op[5:4] != 2'h3);
         endcase
      end
      return f;
   endfunction

   // Split of the first word of an instruction
   logic [7:0] hi_b;
   logic [7:0] lo_b;
   logic       is_pre;
   page_t      dec_page;
   logic [7:0] dec_op;
   fmt_t       dec_fmt;
   logic       got;
   assign hi_b     = mem_rdata[15:8];
   assign lo_b     = mem_rdata[7:0];
   assign is_pre   = (hi_b == `PREBYTE_P1) || (hi_b == `PREBYTE_P2) ||
                     (hi_b == `PREBYTE_P3);
   assign dec_page = is_pre ? hi_b[5:4] : 2'h0;
   assign dec_op   = is_pre ? lo_b : hi_b;
   assign dec_fmt  = decode_fmt(dec_page, dec_op);
   assign got      = mem_ack && mem_req;

   // Special operations of the instruction now being issued
   logic ex;
   logic is_tsx, is_tsy, is_txs, is_tys, is_txy, is_tyx;
   logic is_rti, is_rts, is_wai, is_jmp, is_jsr, use_idx;
   logic [19:0] off20;
   logic [19:0] tgt;
   logic        first_arg;
   assign ex      = (st_ff == S_EXEC) && !cur_ff.illegal;
   assign is_tsx  = cur_ff.page == `PG_XFER && cur_ff.opcode == `OP_TSX;
   assign is_tsy  = cur_ff.page == `PG_XFER && cur_ff.opcode == `OP_TSY;
   assign is_txs  = cur_ff.page == `PG_XFER && cur_ff.opcode == `OP_TXS;
   assign is_tys  = cur_ff.page == `PG_XFER && cur_ff.opcode == `OP_TYS;
   assign is_txy  = cur_ff.page == `PG_XFER && cur_ff.opcode == `OP_TXY;
   assign is_tyx  = cur_ff.page == `PG_XFER && cur_ff.opcode == `OP_TYX;
   assign is_rti  = cur_ff.page == `PG_RET && cur_ff.opcode == `OP_RTI;
   assign is_rts  = cur_ff.page == `PG_RET && cur_ff.opcode == `OP_RTS;
   assign is_wai  = cur_ff.page == `PG_RET && cur_ff.opcode == `OP_WAI;
   assign is_jmp  = cur_ff.page == `PG_JUMP &&
                    (cur_ff.opcode == `OP_JMP_EXT || cur_ff.opcode == `OP_JMP_IND);
   assign is_jsr  = cur_ff.page == `PG_JUMP &&
                    (cur_ff.opcode == `OP_JSR_EXT || cur_ff.opcode == `OP_JSR_IND);
   assign use_idx = cur_ff.opcode == `OP_JMP_IND || cur_ff.opcode == `OP_JSR_IND;
   // Extension nibble joins the operand word into a 20-bit address
   assign off20   = {cur_ff.imm8[3:0], cur_ff.word1};
   assign tgt     = use_idx ? index_x + off20 : off20;
   assign first_arg = (words_left_ff == cur_ff.len_bytes[2:1] - 2'h1);

   // Word requests; odd addresses are impossible by construction
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         mem_req  <= 1'b0;
         mem_addr <= 20'h00000;
      end else if (mem_ack) begin
         mem_req <= 1'b0;
      end else if (!mem_req && (st_ff == S_OPW || st_ff == S_ARGW || st_ff == S_POP)) begin
         mem_req  <= 1'b1;
         if (st_ff == S_POP) begin
            mem_addr <= {stack_ptr[19:1] + 19'h00001, 1'b0};
         end else begin
            mem_addr <= {prog_cnt[19:1], 1'b0};
         end
      end
   end

   // Sequencer: first word, operand words, issue, pops, wait
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         st_ff         <= S_OPW;
         cur_ff        <= '0;
         words_left_ff <= 2'h0;
         pop_cnt_ff    <= 2'h0;
         pop_rti_ff    <= 1'b0;
      end else begin
         case (st_ff)
            S_OPW: begin
               if (got) begin
                  cur_ff.illegal   <= !dec_fmt.legal;
                  cur_ff.len_bytes <= `WORD_BYTES + {dec_fmt.words, 1'b0};
                  cur_ff.page      <= dec_page;
                  cur_ff.opcode    <= dec_op;
                  cur_ff.kind      <= dec_fmt.kind;
                  // Page zero carries its byte operand in the same word
                  case (dec_fmt.kind)
                     ARG_IMM8: cur_ff.imm8 <= lo_b;
                     ARG_NIBZ: cur_ff.imm8 <= {4'h0, lo_b[3:0]};
                     default:  cur_ff.imm8 <= 8'h00;
                  endcase
                  cur_ff.nib_x     <= (dec_fmt.kind == ARG_PAIR) ? lo_b[7:4] : 4'h0;
                  cur_ff.nib_y     <= (dec_fmt.kind == ARG_PAIR) ? lo_b[3:0] : 4'h0;
                  cur_ff.word1     <= 16'h0000;
                  cur_ff.word2     <= 16'h0000;
                  words_left_ff    <= dec_fmt.words;
                  st_ff            <= (dec_fmt.words == 2'h0) ? S_EXEC : S_ARGW;
               end
            end
            S_ARGW: begin
               if (got) begin
                  if (first_arg) begin
                     cur_ff.word1 <= mem_rdata;
                  end else begin
                     cur_ff.word2 <= mem_rdata;
                  end
                  words_left_ff <= words_left_ff - 2'h1;
                  if (words_left_ff == 2'h1) begin
                     st_ff <= S_EXEC;
                  end
               end
            end
            S_EXEC: begin
               if (ex && (is_rti || is_rts)) begin
                  pop_cnt_ff <= `POP_WORDS;
                  pop_rti_ff <= is_rti;
                  st_ff      <= S_POP;
               end else if (ex && is_wai) begin
                  st_ff <= S_WAIT;
               end else begin
                  st_ff <= S_OPW;
               end
            end
            S_POP: begin
               if (got) begin
                  pop_cnt_ff <= pop_cnt_ff - 2'h1;
                  if (pop_cnt_ff == 2'h1) begin
                     st_ff <= S_OPW;
                  end
               end
            end
            S_WAIT: begin
               // No timeout: only an interrupt or reset leaves this state
               if (irq_req) begin
                  st_ff <= S_OPW;
               end
            end
            default: st_ff <= S_OPW;
         endcase
      end
   end

   // Issue strobes toward the core
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         instr_valid <= 1'b0;
         instr       <= '0;
         illegal_op  <= 1'b0;
         call_op     <= 1'b0;
         waiting     <= 1'b0;
      end else begin
         instr_valid <= (st_ff == S_EXEC);
         if (st_ff == S_EXEC) begin
            instr <= cur_ff;
         end
         illegal_op  <= (st_ff == S_EXEC) && cur_ff.illegal;
         call_op     <= ex && is_jsr;
         waiting     <= (ex && is_wai) || (st_ff == S_WAIT && !irq_req);
      end
   end

   // Program counter: word steps, jumps and the popped return address
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         prog_cnt <= `PC_RESET;
      end else if (got && (st_ff == S_OPW || st_ff == S_ARGW)) begin
         prog_cnt <= prog_cnt + `STACK_STEP;
      end else if (ex && (is_jmp || is_jsr)) begin
         prog_cnt <= {tgt[19:1], 1'b0};
      end else if (got && st_ff == S_POP) begin
         if (pop_cnt_ff == `POP_WORDS) begin
            prog_cnt[19:16] <= mem_rdata[3:0];
         end else begin
            prog_cnt[15:0] <= {mem_rdata[15:1], 1'b0};
         end
      end
   end

   // Register file; internal sequencing wins over the core write port
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         stack_ptr          <= `SP_RESET;
         index_x            <= `IDX_RESET;
         index_y            <= `IDX_RESET;
         condition_code_reg <= `CCR_RESET;
      end else if (got && st_ff == S_POP) begin
         stack_ptr <= stack_ptr + `STACK_STEP;
         // Only the first word of an interrupt frame touches flags
         if (pop_rti_ff && pop_cnt_ff == `POP_WORDS) begin
            condition_code_reg <= mem_rdata;
         end
      end else if (ex) begin
         if (is_tsx) index_x <= stack_ptr + `STACK_STEP;
         if (is_tsy) index_y <= stack_ptr + `STACK_STEP;
         if (is_txs) stack_ptr <= index_x - `STACK_STEP;
         if (is_tys) stack_ptr <= index_y - `STACK_STEP;
         if (is_txy) index_y <= index_x;
         if (is_tyx) index_x <= index_y;
      end else if (reg_wr_en) begin
         case (reg_wr_sel)
            2'h0:    stack_ptr <= reg_wr_data;
            2'h1:    index_x <= reg_wr_data;
            2'h2:    index_y <= reg_wr_data;
            default: condition_code_reg <= reg_wr_data[15:0];
         endcase
      end
   end

   // Checks
   sequence seq_first_word;
      st_ff == S_OPW && got;
   endsequence
   sequence seq_issue_rti;
      ex && is_rti;
   endsequence

   chk_addr_even: assert property (@(posedge sys_clk) disable iff (!rst_n)
      mem_req |-> mem_addr[0] == 1'b0) else $error("odd fetch address");
   chk_prebyte_page: assert property (@(posedge sys_clk) disable iff (!rst_n)
      seq_first_word ##0 is_pre |=> {2'h0, cur_ff.page, 4'h7} == $past(hi_b) && cur_ff.page != 2'h0)
      else $error("prebyte did not select its page");
   chk_page0_alone: assert property (@(posedge sys_clk) disable iff (!rst_n)
      seq_first_word ##0 !is_pre |=> cur_ff.page == 2'h0 && cur_ff.opcode == $past(hi_b))
      else $error("page zero opcode misdecoded");
   chk_len_bound: assert property (@(posedge sys_clk) disable iff (!rst_n)
      instr_valid |-> instr.len_bytes[0] == 1'b0 && instr.len_bytes <= `MAX_LEN)
      else $error("instruction length out of range");
   chk_nib_zext: assert property (@(posedge sys_clk) disable iff (!rst_n)
      instr_valid && instr.kind == ARG_NIBZ |-> instr.imm8[7:4] == 4'h0)
      else $error("nibble operand not zero-extended");
   chk_tsx_plus2: assert property (@(posedge sys_clk) disable iff (!rst_n)
      ex && is_tsx |=> index_x == $past(stack_ptr) + `STACK_STEP)
      else $error("stack to index did not add two");
   chk_txs_minus2: assert property (@(posedge sys_clk) disable iff (!rst_n)
      ex && is_txs |=> stack_ptr == $past(index_x) - `STACK_STEP)
      else $error("index to stack did not subtract two");
   chk_txy_ext: assert property (@(posedge sys_clk) disable iff (!rst_n)
      ex && is_txy |=> index_y[19:16] == $past(index_x[19:16]))
      else $error("extension field not copied");
   chk_rti_only: assert property (@(posedge sys_clk) disable iff (!rst_n)
      seq_issue_rti |=> $stable(index_x) && $stable(index_y) && st_ff == S_POP)
      else $error("interrupt return touched other registers");
   chk_ret_frame: assert property (@(posedge sys_clk) disable iff (!rst_n)
      ex && (is_rti || is_rts) ##1 (st_ff == S_POP) [*1] |->
      pop_cnt_ff == `POP_WORDS) else $error("return frame is not two words");
   chk_wait_hold: assert property (@(posedge sys_clk) disable iff (!rst_n)
      st_ff == S_WAIT && !irq_req |=> st_ff == S_WAIT && !mem_req)
      else $error("wait left without interrupt");
   chk_illegal_flag: assert property (@(posedge sys_clk) disable iff (!rst_n)
      seq_first_word ##0 !dec_fmt.legal |=> ##1 illegal_op && !call_op && !waiting)
      else $error("undefined opcode not flagged");
   chk_jump_target: assert property (@(posedge sys_clk) disable iff (!rst_n)
      ex && is_jmp && !use_idx |=> prog_cnt == ($past(off20) & 20'hFFFFE))
      else $error("extended jump target wrong");

endmodule

// >>> pdec_defs.svh
// Constants for the paged instruction decoder
`ifndef PDEC_DEFS_SVH
`define PDEC_DEFS_SVH
// Page-select bytes found on page zero
`define PREBYTE_P1   8'h17
`define PREBYTE_P2   8'h27
`define PREBYTE_P3   8'h37
// Opcodes handled inside the front end
`define OP_JMP_EXT   8'h8A
`define OP_JMP_IND   8'h8B
`define OP_JSR_EXT   8'h8C
`define OP_JSR_IND   8'h8D
`define OP_RTI       8'h07
`define OP_RTS       8'h08
`define OP_WAI       8'h09
`define OP_TSX       8'h10
`define OP_TSY       8'h11
`define OP_TXS       8'h12
`define OP_TYS       8'h13
`define OP_TXY       8'h14
`define OP_TYX       8'h15
// Pages of the opcodes above
`define PG_JUMP      2'h0
`define PG_RET       2'h2
`define PG_XFER      2'h3
// Stack step, frame size and length figures
`define STACK_STEP   20'h00002
`define POP_WORDS    2'h2
`define WORD_BYTES   3'h2
`define MAX_LEN      3'h6
// Reset values
`define PC_RESET     20'h00000
`define SP_RESET     20'h003FE
`define IDX_RESET    20'h00000
`define CCR_RESET    16'h0000
`endif

// >>> pdec_pkg.sv
// Types shared by the paged instruction decoder
package pdec_pkg;
   typedef logic [1:0] page_t;
   typedef enum logic [1:0] {
      ARG_NONE = 2'h0,
      ARG_IMM8 = 2'h1,
      ARG_NIBZ = 2'h2,
      ARG_PAIR = 2'h3
   } arg_kind_t;
   typedef struct packed {
      logic       legal;
      arg_kind_t  kind;
      logic [1:0] words;
   } fmt_t;
   typedef struct packed {
      logic        illegal;
      logic [2:0]  len_bytes;
      page_t       page;
      logic [7:0]  opcode;
      arg_kind_t   kind;
      logic [7:0]  imm8;
      logic [3:0]  nib_x;
      logic [3:0]  nib_y;
      logic [15:0] word1;
      logic [15:0] word2;
   } instr_t;
   typedef enum logic [4:0] {
      S_OPW  = 5'h01,
      S_ARGW = 5'h02,
      S_EXEC = 5'h04,
      S_POP  = 5'h08,
      S_WAIT = 5'h10
   } state_t;
endpackage

// >>> prog_mem_model.sv
// Program memory model answering word fetches after a chosen latency
`timescale 1ns/1ps
module prog_mem_model (
   // Clock and reset
   input  wire logic        sys_clk,
   input  wire logic        rst_n,
   // Fetch port
   input  wire logic        mem_req,
   input  wire logic [19:0] mem_addr,
   output logic [15:0]      mem_rdata,
   output logic             mem_ack,
   // Control and observation
   input  wire logic [3:0]  lat,
   output logic [19:0]      last_addr,
   output logic [7:0]       odd_count
);
   logic [15:0] mem [0:1023];
   logic [3:0]  wait_ff;

   // Ack a standing request after lat cycles; 2 KB window aliases upper address bits
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         mem_ack   <= 1'b0;
         wait_ff   <= 4'h0;
         mem_rdata <= 16'hFFFF;
         last_addr <= 20'h00000;
         odd_count <= 8'h00;
      end else if (mem_ack || !mem_req) begin
         // Stale data is scrambled, never held, so late sampling shows up
         mem_ack   <= 1'b0;
         wait_ff   <= 4'h0;
         mem_rdata <= ~mem_rdata;
      end else if (wait_ff >= lat) begin
         mem_ack   <= 1'b1;
         mem_rdata <= mem[mem_addr[10:1]]; // Whole words only
         last_addr <= mem_addr;
         if (mem_addr[0]) begin
            odd_count <= odd_count + 8'h01; // Odd fetch address noted
         end
      end else begin
         wait_ff   <= wait_ff + 4'h1;
         mem_rdata <= ~mem_rdata;
      end
   end
endmodule

// >>> tb.sv
// Self-checking bench for the paged instruction decoder
`timescale 1ns/1ps
module tb
   import pdec_pkg::*;
;
   logic        sys_clk;
   logic        rst_n;
   logic        mem_req;
   logic [19:0] mem_addr;
   logic [15:0] mem_rdata;
   logic        mem_ack;
   logic        irq_req;
   logic        reg_wr_en;
   logic [1:0]  reg_wr_sel;
   logic [19:0] reg_wr_data;
   logic        instr_valid;
   instr_t      instr;
   logic        illegal_op;
   logic        call_op;
   logic        waiting;
   logic [19:0] prog_cnt;
   logic [19:0] stack_ptr;
   logic [19:0] index_x;
   logic [19:0] index_y;
   logic [15:0] condition_code_reg;
   logic [3:0]  lat;
   logic [19:0] last_addr;
   logic [7:0]  odd_count;
   int          fail_count;
   int          checks_done;
   int          cycles;
   // Program image {address, word}; each encoding has an even byte count
   logic [27:0] image [$] = '{
      28'h00005A5, 28'h0024C3B, 28'h00481F7, 28'h0061234, 28'h008C299, 28'h00AAAAA,
      28'h00C5555, 28'h00E1700, 28'h0102701, 28'h0123702, 28'h0141745, 28'h016BEEF,
      28'h0181781, 28'h01A1111, 28'h01C2222, 28'h01E17F0, 28'h02037F3, 28'h0223710,
      28'h0240100, 28'h0263711, 28'h0280100, 28'h02A3714, 28'h02C0100, 28'h02E3715,
      28'h0300100, 28'h0323712, 28'h0340100, 28'h0363713, 28'h0380100, 28'h03A8A01,
      28'h03C0100, 28'h1000111, 28'h1028B00, 28'h1040020, 28'h1200122, 28'h1228C00,
      28'h1240200, 28'h2000177, 28'h2028D00, 28'h2040041, 28'h1400140, 28'h1422708,
      28'h400FFF0, 28'h4020300, 28'h3000133, 28'h3022707, 28'h4041230, 28'h4060320,
      28'h3200144, 28'h3222709, 28'h3240155, 28'h3268105, 28'h3284321, 28'h32A0166
   };

   // Design and its program memory
   paged_instruction_decoder dut_u (
      .sys_clk(sys_clk), .rst_n(rst_n), .mem_req(mem_req), .mem_addr(mem_addr),
      .mem_rdata(mem_rdata), .mem_ack(mem_ack), .irq_req(irq_req), .reg_wr_en(reg_wr_en),
      .reg_wr_sel(reg_wr_sel), .reg_wr_data(reg_wr_data), .instr_valid(instr_valid),
      .instr(instr), .illegal_op(illegal_op), .call_op(call_op), .waiting(waiting),
      .prog_cnt(prog_cnt), .stack_ptr(stack_ptr), .index_x(index_x), .index_y(index_y),
      .condition_code_reg(condition_code_reg)
   );
   prog_mem_model mem_u (
      .sys_clk(sys_clk), .rst_n(rst_n), .mem_req(mem_req), .mem_addr(mem_addr),
      .mem_rdata(mem_rdata), .mem_ack(mem_ack), .lat(lat), .last_addr(last_addr),
      .odd_count(odd_count)
   );

   // 50 MHz clock
   initial begin
      sys_clk = 1'b0;
      forever #10 sys_clk = ~sys_clk;
   end

   task automatic complete_run();
      $display("checks %0d mismatches %0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   // Hang guard; the whole program needs well under a thousand cycles
   always @(posedge sys_clk) begin
      cycles++;
      if (cycles == 5000) begin
         fail_count++;
         complete_run();
      end
   end

   task automatic check(input string what, input logic [63:0] exp, input logic [63:0] got);
      checks_done++;
      if (got !== exp) begin
         fail_count++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask

   // Sample at falling edges, where the one-cycle issue pulse has settled
   task automatic expect_op(input page_t pg, input logic [7:0] op, input logic [2:0] len);
      int n;
      n = 0;
      @(negedge sys_clk);
      while (instr_valid !== 1'b1 && n < 400) begin
         @(negedge sys_clk);
         n++;
      end
      check("issue", 1'b1, instr_valid);
      check("page", pg, instr.page);
      check("opcode", op, instr.opcode);
      check("length", len, instr.len_bytes);
      check("illegal", op[7:4] == 4'hF && pg != 2'h0, illegal_op);
      check("illegal bit", op[7:4] == 4'hF && pg != 2'h0, instr.illegal);
   endtask

   task automatic wr(input logic [1:0] sel, input logic [19:0] data);
      reg_wr_en   = 1'b1;
      reg_wr_sel  = sel;
      reg_wr_data = data;
      @(negedge sys_clk);
      reg_wr_en   = 1'b0;
   endtask

   task automatic land(input logic [19:0] a);
      expect_op(2'h0, 8'h01, 3'h2);
      check("fetch address", a, last_addr);
      check("pc after landing", a + 20'h00002, prog_cnt);
   endtask

   // Call pulse stands in the same cycle as the issue pulse
   task automatic call_next(input logic exp);
      check("call pulse", exp, call_op);
   endtask

   task automatic formats();
      expect_op(2'h0, 8'h05, 3'h2);
      check("kind", ARG_IMM8, instr.kind);
      check("imm8", 8'hA5, instr.imm8);
      expect_op(2'h0, 8'h4C, 3'h2);
      check("nib x", 4'h3, instr.nib_x);
      check("nib y", 4'hB, instr.nib_y);
      expect_op(2'h0, 8'h81, 3'h4);
      check("zero ext", 8'h07, instr.imm8);
      check("word1", 16'h1234, instr.word1);
      expect_op(2'h0, 8'hC2, 3'h6);
      check("word1 b", 16'hAAAA, instr.word1);
      check("word2 b", 16'h5555, instr.word2);
   endtask

   task automatic pages();
      for (int p = 1; p < 4; p++) begin
         expect_op(page_t'(p), 8'(p - 1), 3'h2);
      end
      expect_op(2'h1, 8'h45, 3'h4);
      check("word1 p1", 16'hBEEF, instr.word1);
      expect_op(2'h1, 8'h81, 3'h6);
      check("word2 p1", 16'h2222, instr.word2);
      expect_op(2'h1, 8'hF0, 3'h2);
      expect_op(2'h3, 8'hF3, 3'h2);
   endtask

   // Transfer, then a plain op, then look at the destination
   task automatic xfer(input logic [7:0] op, input logic [1:0] sel, input logic [19:0] exp);
      expect_op(2'h3, op, 3'h2);
      expect_op(2'h0, 8'h01, 3'h2);
      check("transfer", exp, sel == 2'h0 ? stack_ptr : (sel == 2'h1 ? index_x : index_y));
   endtask

   task automatic transfers();
      wr(2'h0, 20'h51230);
      xfer(8'h10, 2'h1, 20'h51232);
      xfer(8'h11, 2'h2, 20'h51232);
      wr(2'h1, 20'hA0010);
      xfer(8'h14, 2'h2, 20'hA0010);
      wr(2'h2, 20'h60040);
      xfer(8'h15, 2'h1, 20'h60040);
      xfer(8'h12, 2'h0, 20'h6003E);
      wr(2'h2, 20'h00400);
      xfer(8'h13, 2'h0, 20'h003FE);
   endtask

   task automatic jumps();
      wr(2'h1, 20'h00100);
      expect_op(2'h0, 8'h8A, 3'h4);
      call_next(1'b0);
      land(20'h10100);
      expect_op(2'h0, 8'h8B, 3'h4);
      land(20'h00120);
      expect_op(2'h0, 8'h8C, 3'h4);
      call_next(1'b1);
      land(20'h00200);
      expect_op(2'h0, 8'h8D, 3'h4);
      call_next(1'b1);
      land(20'h00140);
   endtask

   task automatic returns();
      expect_op(2'h2, 8'h08, 3'h2);
      land(20'h00300);
      check("stack after pop", 20'h00402, stack_ptr);
      wr(2'h3, 20'h0ABCD);
      check("ccr write", 16'hABCD, condition_code_reg);
      expect_op(2'h2, 8'h07, 3'h2);
      land(20'h00320);
      check("ccr", 16'h1230, condition_code_reg);
      check("x kept", 20'h00100, index_x);
      check("y kept", 20'h00400, index_y);
      check("stack rti", 20'h00406, stack_ptr);
   endtask

   // Long stall with no fetches, left only by the interrupt line
   task automatic wait_test();
      int n;
      n = 0;
      expect_op(2'h2, 8'h09, 3'h2);
      repeat (3) @(negedge sys_clk);
      check("waiting", 1'b1, waiting);
      repeat (60) begin
         @(negedge sys_clk);
         n += (mem_req !== 1'b0);
      end
      check("fetch in wait", 0, n);
      irq_req = 1'b1;
      expect_op(2'h0, 8'h01, 3'h2);
      irq_req = 1'b0;
      check("wait left", 1'b0, waiting);
   endtask

   task automatic slow();
      lat = 4'h3;
      expect_op(2'h0, 8'h81, 3'h4);
      check("slow word", 16'h4321, instr.word1);
      check("slow imm", 8'h05, instr.imm8);
      land(20'h0032A);
      lat = 4'h0;
      check("odd fetches", 8'h00, odd_count);
   endtask

   // Reset, load the image, run every scenario
   initial begin
      rst_n       = 1'b0;
      irq_req     = 1'b0;
      reg_wr_en   = 1'b0;
      reg_wr_sel  = 2'h0;
      reg_wr_data = 20'h00000;
      lat         = 4'h0;
      fail_count  = 0;
      checks_done = 0;
      cycles      = 0;
      for (int i = 0; i < 1024; i++) begin
         mem_u.mem[i] = 16'h0000;
      end
      foreach (image[i]) begin
         mem_u.mem[image[i][26:17]] = image[i][15:0];
      end
      repeat (10) @(negedge sys_clk);
      rst_n = 1'b1;
      formats();
      pages();
      transfers();
      jumps();
      returns();
      wait_test();
      slow();
      complete_run();
   end
endmodule
